/* logic/msq_pkg.sv */
// Constants shared by the measurement mode sequencer.
// Assumes a 32-bit AXI4-Lite bus, where each register sits at word index * 4.
package msq_pkg;
  localparam int NUM_CH_DEF = 6;
  localparam int OUT_BYTES = 26;
  localparam int RES_W = 24;
  localparam int AXI_AW = 8;
  // Register word indices; byte address is index * 4
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_CHAN_EN = 8'h01;
  localparam logic [7:0] IDX_CH_CFG0 = 8'h02;
  localparam logic [7:0] IDX_TICK_DIV = 8'h08;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h09;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h0A;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h0B;
  localparam logic [7:0] IDX_OUT_FIRST = 8'h13;
  localparam logic [7:0] IDX_OUT_LAST = 8'h2C;
  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam int CFG_OUT24_BIT = 0;
  localparam int CFG_CNT_LSB = 1;
  localparam int CFG_CNT_MSB = 2;
  localparam int CFG_PER_LSB = 8;
  localparam int CFG_PER_W = 8;
  // Reset values
  localparam logic [31:0] RST_CH_CFG = 32'h0000_0100;
  localparam logic [15:0] RST_TICK_DIV = 16'h0001;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b11
  } msq_state_t;
endpackage

/* logic/msq_sequencer.sv */
// Measurement mode sequencer: timed repeating and single-shot channel runs,
// result byte packing, completion flags with interrupt, AXI4-Lite registers.
// Assumes a measurement engine on clk answering measStart with measDone,
// and a free-running link clock pin used as the timer time base.
// Operation
// - Host configures timers, then start repeats measurements
// - Channel measured whenever its own timer expires
// - Completion sets channel flag; interrupt if enabled
// - Timer restarts after completion, then waits again
// - Single-shot runs each enabled non-counter channel exactly once
// - Single-shot channels run back-to-back, ascending
// - Single-shot flags all set together at end
// - Single-shot skips channels selecting a counter
// - 24-bit three bytes, 16-bit two, MSB first
// - Results packed lowest channel first from 0x13
// - Reported result stays until channel's next reading
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module msq_sequencer #(
  parameter int NUM_CH = msq_pkg::NUM_CH_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [msq_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [msq_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic linkClk,
  output logic measStart,
  output logic [2:0] measChan,
  input wire logic measDone,
  input wire logic [msq_pkg::RES_W-1:0] measResult,
  output logic irq
);
  generate
    if (NUM_CH < 1 || NUM_CH > 8 || NUM_CH * 3 > msq_pkg::OUT_BYTES) begin
      $error("NUM_CH outside what the output field can hold");
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Link clock sampling and timer time base
  logic linkMeta, linkSync, linkPrev;
  logic [15:0] divCnt, next_divCnt;
  logic tick;
  logic [15:0] tickDiv;

  always_comb begin
    tick = 1'b0;
    next_divCnt = divCnt;
    if (linkSync && !linkPrev) begin
      if (divCnt + 16'h0001 >= tickDiv) begin
        next_divCnt = 16'h0000;
        tick = 1'b1;
      end else begin
        next_divCnt = divCnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkMeta <= 1'b0;
      linkSync <= 1'b0;
      linkPrev <= 1'b0;
      divCnt <= 16'h0000;
    end else begin
      linkMeta <= linkClk;
      linkSync <= linkMeta;
      linkPrev <= linkSync;
      divCnt <= next_divCnt;
    end
  end

  // Bus handshake
  logic wrFire, rdFire;
  logic [7:0] wrIdx, rdIdx;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rdMux;
  logic wrMapped, rdMapped;

  logic run, next_run;
  logic forcing, next_forcing;
  logic [NUM_CH-1:0] chanEn, next_chanEn;
  logic [31:0] chCfg [NUM_CH];
  logic [31:0] next_chCfg [NUM_CH];
  logic [15:0] next_tickDiv;
  logic [NUM_CH-1:0] irqStatus, next_irqStatus;
  logic [NUM_CH-1:0] irqEnable, next_irqEnable;
  logic [7:0] outBytes [msq_pkg::OUT_BYTES];
  logic [7:0] next_outBytes [msq_pkg::OUT_BYTES];

  assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rdFire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_arready = rdFire;
  assign wrIdx = {2'b00, s_axi_awaddr[7:2]};
  assign rdIdx = {2'b00, s_axi_araddr[7:2]};

  function automatic logic mapped(input logic [7:0] idx, input int n);
    return idx == msq_pkg::IDX_CTRL || idx == msq_pkg::IDX_CHAN_EN ||
      (idx >= msq_pkg::IDX_CH_CFG0 &&
       idx < msq_pkg::IDX_CH_CFG0 + 8'(n)) ||
      idx == msq_pkg::IDX_TICK_DIV || idx == msq_pkg::IDX_IRQ_STATUS ||
      idx == msq_pkg::IDX_IRQ_CLEAR || idx == msq_pkg::IDX_IRQ_ENABLE ||
      (idx >= msq_pkg::IDX_OUT_FIRST && idx <= msq_pkg::IDX_OUT_LAST);
  endfunction

  assign wrMapped = mapped(wrIdx, NUM_CH);
  assign rdMapped = mapped(rdIdx, NUM_CH);

  always_comb begin
    rdMux = 32'h0000_0000;
    if (rdIdx == msq_pkg::IDX_CTRL) begin
      rdMux[msq_pkg::CTRL_RUN_BIT] = run;
      rdMux[msq_pkg::CTRL_FORCE_BIT] = forcing;
    end else if (rdIdx == msq_pkg::IDX_CHAN_EN) begin
      rdMux[NUM_CH-1:0] = chanEn;
    end else if (rdIdx >= msq_pkg::IDX_CH_CFG0 &&
                 rdIdx < msq_pkg::IDX_CH_CFG0 + 8'(NUM_CH)) begin
      rdMux = chCfg[3'(rdIdx - msq_pkg::IDX_CH_CFG0)];
    end else if (rdIdx == msq_pkg::IDX_TICK_DIV) begin
      rdMux[15:0] = tickDiv;
    end else if (rdIdx == msq_pkg::IDX_IRQ_STATUS) begin
      rdMux[NUM_CH-1:0] = irqStatus;
    end else if (rdIdx == msq_pkg::IDX_IRQ_ENABLE) begin
      rdMux[NUM_CH-1:0] = irqEnable;
    end else if (rdIdx >= msq_pkg::IDX_OUT_FIRST &&
                 rdIdx <= msq_pkg::IDX_OUT_LAST) begin
      rdMux[7:0] = outBytes[5'(rdIdx - msq_pkg::IDX_OUT_FIRST)];
    end
  end

  always_comb begin
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wrFire) begin
      next_bvalid = 1'b1;
      next_bresp = wrMapped ? msq_pkg::RESP_OKAY : msq_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rdFire) begin
      next_rvalid = 1'b1;
      next_rresp = rdMapped ? msq_pkg::RESP_OKAY : msq_pkg::RESP_SLVERR;
      next_rdata = rdMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Sequencer, timers, configuration and result field
  msq_pkg::msq_state_t state, next_state;
  logic [2:0] curChan, next_curChan;
  logic curForced, next_curForced;
  logic [NUM_CH-1:0] pend, next_pend;
  logic [NUM_CH-1:0] forceLeft, next_forceLeft;
  logic [NUM_CH-1:0] forceAcc, next_forceAcc;
  logic [msq_pkg::CFG_PER_W-1:0] timer [NUM_CH];
  logic [msq_pkg::CFG_PER_W-1:0] next_timer [NUM_CH];

  assign measStart = (state == msq_pkg::ST_ISSUE);
  assign measChan = curChan;
  assign irq = |(irqStatus & irqEnable);

  always_comb begin
    logic [31:0] wd;
    logic [NUM_CH-1:0] setMask, clrMask, candMask, noCnt;
    logic [4:0] off;
    logic found;
    wd = 32'h0000_0000;
    setMask = '0;
    clrMask = '0;
    candMask = '0;
    noCnt = '0;
    off = 5'h00;
    found = 1'b0;
    next_run = run;
    next_forcing = forcing;
    next_chanEn = chanEn;
    next_tickDiv = tickDiv;
    next_irqEnable = irqEnable;
    next_state = state;
    next_curChan = curChan;
    next_curForced = curForced;
    next_pend = pend;
    next_forceLeft = forceLeft;
    next_forceAcc = forceAcc;
    for (int i = 0; i < NUM_CH; i++) begin
      next_chCfg[i] = chCfg[i];
      next_timer[i] = timer[i];
      noCnt[i] = chCfg[i][msq_pkg::CFG_CNT_MSB:msq_pkg::CFG_CNT_LSB] == '0;
    end
    for (int k = 0; k < msq_pkg::OUT_BYTES; k++) begin
      next_outBytes[k] = outBytes[k];
    end
    if (wrFire) begin
      if (wrIdx == msq_pkg::IDX_CTRL && s_axi_wstrb[0]) begin
        next_run = s_axi_wdata[msq_pkg::CTRL_RUN_BIT];
        if (s_axi_wdata[msq_pkg::CTRL_FORCE_BIT] && !forcing) begin
          // Empty set would leave the command pending forever
          next_forcing = |(chanEn & noCnt);
          next_forceLeft = chanEn & noCnt;
          next_forceAcc = '0;
        end
      end else if (wrIdx == msq_pkg::IDX_CHAN_EN) begin
        wd = merge(32'(chanEn), s_axi_wdata, s_axi_wstrb);
        next_chanEn = wd[NUM_CH-1:0];
      end else if (wrIdx >= msq_pkg::IDX_CH_CFG0 &&
                   wrIdx < msq_pkg::IDX_CH_CFG0 + 8'(NUM_CH)) begin
        next_chCfg[3'(wrIdx - msq_pkg::IDX_CH_CFG0)] =
          merge(chCfg[3'(wrIdx - msq_pkg::IDX_CH_CFG0)], s_axi_wdata,
                s_axi_wstrb);
      end else if (wrIdx == msq_pkg::IDX_TICK_DIV) begin
        wd = merge(32'(tickDiv), s_axi_wdata, s_axi_wstrb);
        next_tickDiv = wd[15:0];
      end else if (wrIdx == msq_pkg::IDX_IRQ_CLEAR) begin
        wd = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
        clrMask = wd[NUM_CH-1:0];
      end else if (wrIdx == msq_pkg::IDX_IRQ_ENABLE) begin
        wd = merge(32'(irqEnable), s_axi_wdata, s_axi_wstrb);
        next_irqEnable = wd[NUM_CH-1:0];
      end
    end
    // Timers run on the link time base; frozen while own reading is pending
    for (int i = 0; i < NUM_CH; i++) begin
      if (!run || !chanEn[i]) begin
        next_timer[i] = chCfg[i][msq_pkg::CFG_PER_LSB +: msq_pkg::CFG_PER_W];
        next_pend[i] = 1'b0;
      end else if (!pend[i] && tick &&
                   !(state != msq_pkg::ST_IDLE && curChan == 3'(i))) begin
        if (timer[i] <= 8'h01) begin
          next_timer[i] = 8'h00;
          next_pend[i] = 1'b1;
        end else begin
          next_timer[i] = timer[i] - 8'h01;
        end
      end
    end
    // Single-shot work goes first; timed pending channels wait behind it
    candMask = forcing ? forceLeft : pend;
    unique case (state)
      msq_pkg::ST_IDLE: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (candMask[i] && !found) begin
            found = 1'b1;
            next_curChan = 3'(i);
          end
        end
        if (found) begin
          next_curForced = forcing;
          next_state = msq_pkg::ST_ISSUE;
        end
      end
      msq_pkg::ST_ISSUE: begin
        next_state = msq_pkg::ST_WAIT;
      end
      msq_pkg::ST_WAIT: begin
        if (measDone) begin
          next_state = msq_pkg::ST_IDLE;
          for (int j = 0; j < NUM_CH; j++) begin
            if (j < int'(curChan) && chanEn[j]) begin
              off = off + (chCfg[j][msq_pkg::CFG_OUT24_BIT] ? 5'd3 : 5'd2);
            end
          end
          // Bytes change only here, so a result holds until the next reading
          if (chCfg[curChan][msq_pkg::CFG_OUT24_BIT]) begin
            next_outBytes[off] = measResult[23:16];
            next_outBytes[off + 5'd1] = measResult[15:8];
            next_outBytes[off + 5'd2] = measResult[7:0];
          end else begin
            next_outBytes[off] = measResult[15:8];
            next_outBytes[off + 5'd1] = measResult[7:0];
          end
          if (curForced) begin
            next_forceLeft[curChan] = 1'b0;
            next_forceAcc[curChan] = 1'b1;
            if ((forceLeft & ~(NUM_CH'(1) << curChan)) == '0) begin
              setMask = forceAcc | (NUM_CH'(1) << curChan);
              next_forcing = 1'b0;
            end
          end else begin
            setMask[curChan] = 1'b1;
            next_pend[curChan] = 1'b0;
            next_timer[curChan] =
              chCfg[curChan][msq_pkg::CFG_PER_LSB +: msq_pkg::CFG_PER_W];
          end
        end
      end
      default: begin
        next_state = msq_pkg::ST_IDLE;
      end
    endcase
    // A new completion wins over a clear in the same cycle
    next_irqStatus = (irqStatus & ~clrMask) | setMask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'b0;
      forcing <= 1'b0;
      chanEn <= '0;
      tickDiv <= msq_pkg::RST_TICK_DIV;
      irqStatus <= '0;
      irqEnable <= '0;
      state <= msq_pkg::ST_IDLE;
      curChan <= 3'h0;
      curForced <= 1'b0;
      pend <= '0;
      forceLeft <= '0;
      forceAcc <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        chCfg[i] <= msq_pkg::RST_CH_CFG;
        timer[i] <= '0;
      end
      for (int k = 0; k < msq_pkg::OUT_BYTES; k++) begin
        outBytes[k] <= 8'h00;
      end
    end else begin
      run <= next_run;
      forcing <= next_forcing;
      chanEn <= next_chanEn;
      tickDiv <= next_tickDiv;
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
      state <= next_state;
      curChan <= next_curChan;
      curForced <= next_curForced;
      pend <= next_pend;
      forceLeft <= next_forceLeft;
      forceAcc <= next_forceAcc;
      for (int i = 0; i < NUM_CH; i++) begin
        chCfg[i] <= next_chCfg[i];
        timer[i] <= next_timer[i];
      end
      for (int k = 0; k < msq_pkg::OUT_BYTES; k++) begin
        outBytes[k] <= next_outBytes[k];
      end
    end
  end
endmodule

/* tb/msq_sequencer_properties.sv */
// Checker on the sequencer's bus and engine ports.
// Bound to each msq_sequencer; sees its ports only.
`timescale 1ns/1ps
module msq_sequencer_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic measStart,
  input wire logic [2:0] measChan,
  input wire logic measDone,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_one_pulse: assert property (measStart |=> !measStart)
    else $error("start pulse longer than one cycle");
  a_chan_held: assert property ($past(measStart) |-> $stable(measChan))
    else $error("channel moved after start");
  a_restart_wait: assert property (measDone |=> !measStart)
    else $error("start right after completion");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(measDone) ||
    $past(s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("irq rose without cause");
  a_write_answer: assert property
    (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property
    (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  c_start: cover property (measStart);
  c_done: cover property (measDone);
  c_irq: cover property ($rose(irq));
endmodule
bind msq_sequencer msq_sequencer_properties u_chk (.clk(clk),
  .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .measStart(measStart),
  .measChan(measChan), .measDone(measDone), .irq(irq));

/* tb/msq_engine_model.sv */
// Behavioural measurement engine facing the sequencer.
// Answers a start after 2 or 7 cycles, chosen by slow.
`timescale 1ns/1ps
module msq_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic measStart,
  input wire logic [2:0] measChan,
  output logic measDone,
  output logic [23:0] measResult
);
  int cnt;
  logic [2:0] chan;
  logic [7:0] seq;
  logic [23:0] noise;
  // Churns between answers so a stale sample cannot pass
  assign measResult = measDone ? {5'h14, chan, seq, 5'h18, chan} : noise;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      measDone <= 1'b0;
      seq <= 8'h00;
      chan <= 3'h0;
      noise <= 24'h5A5A5A;
    end else begin
      noise <= ~noise + 24'h000013;
      measDone <= 1'b0;
      if (measStart) begin
        chan <= measChan;
        cnt <= slow ? 6 : 1;
      end else if (cnt == 1) begin
        measDone <= 1'b1;
        seq <= seq + 8'h01;
        cnt <= 0;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the measurement mode sequencer.
// Registers over AXI4-Lite; engine model answers starts.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic linkClk = 1'b0;
  logic slow = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, measStart, measDone, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] measChan;
  logic [23:0] measResult;
  logic [23:0] lastRes [8];
  logic [2:0] order [$];
  int errorCnt = 0;
  int totalChecks = 0;
  int nDone = 0;
  int cyc = 0;
  int lastStart = 0;
  always #12.5 clk = ~clk;
  always #100 linkClk = ~linkClk;
  msq_sequencer DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .linkClk(linkClk), .measStart(measStart),
    .measChan(measChan), .measDone(measDone),
    .measResult(measResult), .irq(irq));
  msq_engine_model eng (.clk(clk), .rst_n(rst_n), .slow(slow),
    .measStart(measStart), .measChan(measChan), .measDone(measDone),
    .measResult(measResult));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (measStart) begin
      order.push_back(measChan);
      lastStart <= cyc;
    end
    if (measDone) begin
      lastRes[measChan] <= measResult;
      nDone <= nDone + 1;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected %0t %s: %h", $time, m, got);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {i[5:0], 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 && ++n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1 && ++n < 50);
    bready <= 1'b0;
    cmp({31'h0, n < 50}, 32'h1, "write wait");
    cmp({30'h0, bresp}, 32'h0, "write response");
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {i[5:0], 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 50);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 50);
    rready <= 1'b0;
    cmp({31'h0, n < 50}, 32'h1, "read wait");
    cmp(rdata, d, "read data");
    cmp({30'h0, rresp}, {30'h0, r}, "read response");
  endtask
  task automatic waitIrq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, irq}, {31'h0, lvl}, "irq level");
  endtask
  task automatic waitDone(input int target);
    int n;
    n = 0;
    while (nDone < target && n < 3000) begin
      @(posedge clk);
      n++;
    end
    cmp(nDone, target, "completion count");
  endtask
  task automatic resetValues();
    rd(msq_pkg::IDX_CTRL, 32'h0, msq_pkg::RESP_OKAY);
    rd(msq_pkg::IDX_CH_CFG0, msq_pkg::RST_CH_CFG, msq_pkg::RESP_OKAY);
    rd(msq_pkg::IDX_TICK_DIV, {16'h0, msq_pkg::RST_TICK_DIV}, 2'h0);
    rd(8'h30, 32'h0, msq_pkg::RESP_SLVERR);
    wr(msq_pkg::IDX_IRQ_STATUS, 32'h0000_00FF);
    rd(msq_pkg::IDX_IRQ_STATUS, 32'h0, msq_pkg::RESP_OKAY);
    cmp({31'h0, irq}, 32'h0, "irq after reset");
  endtask
  task automatic singleShot();
    logic [95:0] e;
    int n0;
    // Channel 0 picks a counter: space kept, never measured
    wr(msq_pkg::IDX_CHAN_EN, 32'h0000_003B);
    wr(msq_pkg::IDX_CH_CFG0, 32'h0000_0102);
    wr(msq_pkg::IDX_CH_CFG0 + 8'h01, 32'h0000_0101);
    wr(msq_pkg::IDX_CH_CFG0 + 8'h04, 32'h0000_0101);
    wr(msq_pkg::IDX_IRQ_ENABLE, 32'h0000_003F);
    order.delete();
    n0 = nDone;
    wr(msq_pkg::IDX_CTRL, 32'h0000_0002);
    waitIrq(1'b1);
    cmp(nDone - n0, 4, "flags before last channel");
    cmp(order.size(), 4, "channel count");
    cmp({order[0], order[1], order[2], order[3]}, 12'o1345, "order");
    rd(msq_pkg::IDX_IRQ_STATUS, 32'h3A, msq_pkg::RESP_OKAY);
    e = {16'h0, lastRes[1], lastRes[3][15:0], lastRes[4], lastRes[5][15:0]};
    cmp({8'h0, lastRes[4]}, {8'hA4, lastRes[4][15:8], 8'hC4}, "ch4 data");
    for (int k = 0; k < 12; k++) begin
      rd(msq_pkg::IDX_OUT_FIRST + 8'(k), {24'h0, e[95 - 8 * k -: 8]},
         msq_pkg::RESP_OKAY);
    end
    repeat (200) @(posedge clk);
    cmp(order.size(), 4, "repeat after single shot");
    rd(msq_pkg::IDX_CTRL, 32'h0, msq_pkg::RESP_OKAY);
    wr(msq_pkg::IDX_IRQ_CLEAR, 32'h0000_003F);
    waitIrq(1'b0);
  endtask
  task automatic timed();
    int t0;
    slow <= 1'b0;
    wr(msq_pkg::IDX_IRQ_ENABLE, 32'h0);
    wr(msq_pkg::IDX_CHAN_EN, 32'h0000_0004);
    wr(msq_pkg::IDX_CH_CFG0 + 8'h02, 32'h0000_0401);
    wr(msq_pkg::IDX_TICK_DIV, 32'h0000_0002);
    wr(msq_pkg::IDX_CTRL, 32'h0000_0001);
    waitDone(nDone + 1);
    t0 = cyc;
    waitDone(nDone + 1);
    // Read before the next reading lands
    for (int k = 0; k < 3; k++) begin
      rd(msq_pkg::IDX_OUT_FIRST + 8'(k), {24'h0, lastRes[2][23 - 8 * k -: 8]},
         msq_pkg::RESP_OKAY);
    end
    // Four ticks of 16 cycles after reload; first tick phase unknown
    cmp({31'h0, lastStart - t0 >= 45 && lastStart - t0 <= 70}, 1, "gap");
    cmp({31'h0, irq}, 32'h0, "masked irq");
    rd(msq_pkg::IDX_IRQ_STATUS, 32'h04, msq_pkg::RESP_OKAY);
    wr(msq_pkg::IDX_IRQ_ENABLE, 32'h0000_0004);
    waitIrq(1'b1);
    wr(msq_pkg::IDX_CTRL, 32'h0);
    repeat (100) @(posedge clk);
    wr(msq_pkg::IDX_IRQ_CLEAR, 32'h0000_0004);
    waitIrq(1'b0);
  endtask
  task automatic completeRun();
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #500000;
    errorCnt++;
    $display("unexpected %0t watchdog expired", $time);
    completeRun();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    resetValues();
    singleShot();
    timed();
    completeRun();
  end
endmodule
